// file: srcs_bench.sv
module srcs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0, i_rstn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00, o_rdata, rv;
    logic i_word_valid, i_word_framing_error_flag, o_rx_active, o_data_avail;
    logic [8:0] i_word_data;
    logic [15:0] seed = 16'h2ADD;
    logic [4:0] ctl = 5'h00;
    logic [1:0] mode = 2'h0;
    logic ovr = 1'b0;
    logic [9:0] q[$];
    logic [7:0] cfg[6] = '{8'h98, 8'hD8, 8'hD0, 8'h80, 8'hA0, 8'hB0};
    int n_mismatch = 0, n_checks = 0;
    initial forever #5 i_clk = ~i_clk;
    srcs_top i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_word_valid(i_word_valid), .i_word_data(i_word_data),
        .i_word_framing_error_flag(i_word_framing_error_flag), .o_rx_active(o_rx_active),
        .o_data_avail(o_data_avail));
    srcs_partner i_peer (.i_clk(i_clk), .o_word_valid(i_word_valid),
        .o_word_data(i_word_data), .o_word_framing_error_flag(i_word_framing_error_flag));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic on_now();
        return ctl[4] & (ctl[1] | (mode == 2'h3 & ctl[2]));
    endfunction
    task chk(input logic [9:0] s, input logic [9:0] e);
        n_checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("wrong value at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        if (a == srcs_pkg::ADDR_MODE)
            mode = d[1:0];
        if (a == srcs_pkg::ADDR_CTRL)
        begin
            ctl = d[7:3];
            if (!d[4])
                ovr = 1'b0;
        end
    endtask
    task rd(input logic [3:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 rv = o_rdata;
    endtask
    task snd(input logic [9:0] w);
        if (on_now() && !ovr && (!(ctl[3] && ctl[0] && !mode[0]) || w[8]))
        begin
            if (q.size() == 16)
                ovr = 1'b1;
            else
                q.push_back(w);
            if (mode == 2'h3 && !ctl[1])
                ctl[2] = 1'b0;
        end
        i_peer.send(w);
    endtask
    task drain;
        repeat (3) @(posedge i_clk);
        #1 chk(10'(o_data_avail), 10'(q.size() != 0));
        while (q.size() != 0)
        begin
            rd(srcs_pkg::ADDR_CTRL);
            chk(10'(rv), 10'({ctl, q[0][9], ovr, q[0][8]}));
            rd(srcs_pkg::ADDR_DATA);
            chk(10'(rv), 10'(q[0][7:0]));
            void'(q.pop_front());
        end
        repeat (2) @(posedge i_clk);
        #1 chk(10'(o_rx_active), 10'(on_now()));
        chk(10'(o_data_avail), 10'h000);
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge i_clk);
        i_rstn <= 1'b1;
        rd(srcs_pkg::ADDR_CTRL);
        chk(10'(rv), 10'(srcs_pkg::CTRL_RESET));
        rd(srcs_pkg::ADDR_MODE);
        chk(10'(rv), 10'(srcs_pkg::MODE_RESET));
        $display("test reset done");
        wr(4'hF, 8'hFF);
        rd(4'hF);
        chk(10'(rv), 10'h000);
        wr(srcs_pkg::ADDR_CTRL, 8'h97);
        rd(srcs_pkg::ADDR_CTRL);
        chk(10'(rv & 8'hFA), 10'h090);
        for (int i = 0; i < 6; i++)
        begin
            wr(srcs_pkg::ADDR_MODE, (i > 3) ? 8'h03 : 8'h00);
            wr(srcs_pkg::ADDR_CTRL, cfg[i]);
            repeat (6)
            begin
                seed = lfsr(seed);
                snd({seed[9], seed[8] & ctl[3], seed[7:0]});
            end
            drain();
            $display("test %0d done", i);
        end
        wr(srcs_pkg::ADDR_CTRL, 8'h90);
        repeat (17)
        begin
            seed = lfsr(seed);
            snd({seed[9], 1'b0, seed[7:0]});
        end
        drain();
        wr(srcs_pkg::ADDR_CTRL, 8'h80);
        rd(srcs_pkg::ADDR_CTRL);
        chk(10'(rv & 8'hFA), 10'h080);
        $display("test overrun done");
        complete_run();
    end
    initial
    begin
        #100000;
        n_mismatch++;
        complete_run();
    end
endmodule

// file: srcs_fifo.sv
module srcs_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    wire push = i_in_valid && o_in_ready;
    wire pop = o_out_valid && i_out_ready;
    assign o_in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_r != '0);
    assign o_out_data = mem_r[rp_r];
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
                wp_r <= wp_r + 1'b1;
            if (pop)
                rp_r <= rp_r + 1'b1;
            if (push && !pop)
                cnt_r <= cnt_r + 1'b1;
            else if (pop && !push)
                cnt_r <= cnt_r - 1'b1;
        end
    end
    always_ff @(posedge i_clk)
    begin
        if (push)
            mem_r[wp_r] <= i_in_data;
    end
endmodule

// file: srcs_partner.sv
module srcs_partner (
    input wire logic i_clk,
    output logic o_word_valid,
    output logic [8:0] o_word_data,
    output logic o_word_framing_error_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy = 1'b0;
    initial
    begin
        o_word_valid = 1'b0;
        {o_word_framing_error_flag, o_word_data} = 10'h0AA;
    end
    // Idle lines toggle
    always @(posedge i_clk)
        if (!busy)
            {o_word_framing_error_flag, o_word_data} <= ~{o_word_framing_error_flag, o_word_data};
    task send(input logic [9:0] w);
        @(posedge i_clk);
        busy = 1'b1;
        o_word_valid <= 1'b1;
        {o_word_framing_error_flag, o_word_data} <= w;
        @(posedge i_clk);
        o_word_valid <= 1'b0;
        busy = 1'b0;
    endtask
endmodule

// file: srcs_pkg.sv
package srcs_pkg;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_DATA = 4'h1;
    localparam logic [3:0] ADDR_MODE = 4'h2;
    localparam int BIT_SPEN = 7;
    localparam int BIT_NINE = 6;
    localparam int BIT_SINGLE = 5;
    localparam int BIT_CONT = 4;
    localparam int BIT_ADDR = 3;
    localparam int BIT_FRAMING_ERROR_FLAG = 2;
    localparam int BIT_OVERRUN_ERROR_FLAG = 1;
    localparam int BIT_RX9 = 0;
    localparam int MODE_SYNC = 0;
    localparam int MODE_MASTER = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam int FIFO_DEPTH = 16;
    localparam int WORD_W = 10;
endpackage

// file: srcs_top.sv
// The address-and-strobe port and the address map were decided locally.
module srcs_top (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_word_valid,
    input wire logic [8:0] i_word_data,
    input wire logic i_word_framing_error_flag,
    output logic o_rx_active,
    output logic o_data_avail
);
    logic [7:0] ctrl_r;
    logic [1:0] mode_r;
    logic [7:0] rdata_r;
    logic rx_active_r;
    logic avail_r;
    logic overrun_error_flag_r;
    logic [7:0] ctrl_nxt;
    logic [7:0] rdata_nxt;
    logic overrun_error_flag_nxt;
    logic [9:0] fifo_out;
    logic fifo_ready;
    logic fifo_valid;

    wire sync_mode = mode_r[srcs_pkg::MODE_SYNC];
    wire master = mode_r[srcs_pkg::MODE_MASTER];
    wire spen = ctrl_r[srcs_pkg::BIT_SPEN];
    wire nine = ctrl_r[srcs_pkg::BIT_NINE];
    wire single = ctrl_r[srcs_pkg::BIT_SINGLE];
    wire cont = ctrl_r[srcs_pkg::BIT_CONT];
    wire addr_en = ctrl_r[srcs_pkg::BIT_ADDR];
    wire wr_ctrl = i_wr && (i_addr == srcs_pkg::ADDR_CTRL);
    wire wr_mode = i_wr && (i_addr == srcs_pkg::ADDR_MODE);
    wire rd_data = i_rd && (i_addr == srcs_pkg::ADDR_DATA);
    wire rd_ctrl = i_rd && (i_addr == srcs_pkg::ADDR_CTRL);
    wire rd_mode = i_rd && (i_addr == srcs_pkg::ADDR_MODE);
    // Receiver on: async by continuous; sync by continuous, or by single in master mode only
    wire single_on = sync_mode && master && single && !cont;
    wire rx_on = spen && (cont || single_on);
    // Address filter only in nine-bit async
    wire filt = !sync_mode && nine && addr_en;
    wire keep = !filt || i_word_data[8];
    wire take = rx_on && i_word_valid && keep;
    wire push = take && !overrun_error_flag_r;
    wire lost = take && !fifo_ready;
    wire single_done = single_on && spen && i_word_valid;
    wire push_ok = push && fifo_ready;
    wire [9:0] word_in = {i_word_framing_error_flag, i_word_data};

    srcs_fifo #(
        .WIDTH(srcs_pkg::WORD_W),
        .DEPTH(srcs_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_in_valid(push),
        .o_in_ready(fifo_ready),
        .i_in_data(word_in),
        .o_out_valid(fifo_valid),
        .i_out_ready(rd_data),
        .o_out_data(fifo_out)
    );

    always_comb
    begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl)
        begin
            ctrl_nxt[7:3] = i_wdata[7:3];
        end
        if (single_done && !(wr_ctrl && i_wdata[srcs_pkg::BIT_SINGLE]))
            ctrl_nxt[srcs_pkg::BIT_SINGLE] = 1'b0;
        // Framing and ninth-bit status bits track the head word
        ctrl_nxt[srcs_pkg::BIT_FRAMING_ERROR_FLAG] = fifo_valid && fifo_out[9];
        ctrl_nxt[srcs_pkg::BIT_RX9] = fifo_valid && fifo_out[8];
        ctrl_nxt[srcs_pkg::BIT_OVERRUN_ERROR_FLAG] = 1'b0;
    end

    // Overrun: set wins over clear
    assign overrun_error_flag_nxt = lost || (overrun_error_flag_r && cont);

    always_comb
    begin
        rdata_nxt = 8'h00;
        if (rd_ctrl)
        begin
            rdata_nxt = ctrl_r;
            rdata_nxt[srcs_pkg::BIT_OVERRUN_ERROR_FLAG] = overrun_error_flag_r;
        end
        else if (rd_data)
            rdata_nxt = fifo_valid ? fifo_out[7:0] : 8'h00;
        else if (rd_mode)
            rdata_nxt = {6'h00, mode_r};
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ctrl_r <= srcs_pkg::CTRL_RESET;
            mode_r <= srcs_pkg::MODE_RESET;
            rdata_r <= 8'h00;
            overrun_error_flag_r <= 1'b0;
            rx_active_r <= 1'b0;
            avail_r <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            if (wr_mode)
                mode_r <= i_wdata[1:0];
            rdata_r <= rdata_nxt;
            overrun_error_flag_r <= overrun_error_flag_nxt;
            rx_active_r <= rx_on;
            avail_r <= fifo_valid;
        end
    end

    assign o_rdata = rdata_r;
    assign o_rx_active = rx_active_r;
    assign o_data_avail = avail_r;

    property p_async_off;
        @(posedge i_clk) disable iff (!i_rstn)
        (!sync_mode && !cont) |-> !rx_on;
    endproperty
    a_async_off: assert property (p_async_off)
        else $error("receiver on without continuous enable");

    property p_single_clear;
        @(posedge i_clk) disable iff (!i_rstn)
        (single_done && !wr_ctrl) |=> !single;
    endproperty
    a_single_clear: assert property (p_single_clear)
        else $error("single enable not cleared");

    property p_filter;
        @(posedge i_clk) disable iff (!i_rstn)
        (filt && !i_word_data[8]) |-> !push;
    endproperty
    a_filter: assert property (p_filter)
        else $error("address filter let word through");

    property p_nofilt;
        @(posedge i_clk) disable iff (!i_rstn)
        (rx_on && i_word_valid && !filt && !overrun_error_flag_r && fifo_ready)
            |-> push_ok;
    endproperty
    a_nofilt: assert property (p_nofilt)
        else $error("word dropped without filter");

    property p_eight;
        @(posedge i_clk) disable iff (!i_rstn)
        (!sync_mode && !nine) |-> keep;
    endproperty
    a_eight: assert property (p_eight)
        else $error("address detect acted in eight bit mode");

    property p_overrun_error_flag_set;
        @(posedge i_clk) disable iff (!i_rstn)
        lost |=> overrun_error_flag_r;
    endproperty
    a_overrun_error_flag_set: assert property (p_overrun_error_flag_set)
        else $error("overrun not set");

    property p_overrun_error_flag_hold;
        @(posedge i_clk) disable iff (!i_rstn)
        (overrun_error_flag_r && cont) |=> overrun_error_flag_r;
    endproperty
    a_overrun_error_flag_hold: assert property (p_overrun_error_flag_hold)
        else $error("overrun cleared while enabled");

    property p_framing_error_flag;
        @(posedge i_clk) disable iff (!i_rstn)
        ##1 (ctrl_r[srcs_pkg::BIT_FRAMING_ERROR_FLAG] == $past(fifo_valid && fifo_out[9]));
    endproperty
    a_framing_error_flag: assert property (p_framing_error_flag)
        else $error("framing flag mismatch");

    property p_cont_wins;
        @(posedge i_clk) disable iff (!i_rstn)
        (sync_mode && cont && spen) |-> (rx_on && !single_on);
    endproperty
    a_cont_wins: assert property (p_cont_wins)
        else $error("continuous did not override single");

    property p_rx9;
        @(posedge i_clk) disable iff (!i_rstn)
        fifo_valid |=> (ctrl_r[srcs_pkg::BIT_RX9] == $past(fifo_out[8]));
    endproperty
    a_rx9: assert property (p_rx9)
        else $error("ninth bit altered");

    property p_single_mode;
        @(posedge i_clk) disable iff (!i_rstn)
        single_on |-> (sync_mode && master);
    endproperty
    a_single_mode: assert property (p_single_mode)
        else $error("single receive outside sync master");

    property p_single_hold;
        @(posedge i_clk) disable iff (!i_rstn)
        (single && !single_done && !wr_ctrl) |=> single;
    endproperty
    a_single_hold: assert property (p_single_hold)
        else $error("single enable lost before a word");

    property p_async_on;
        @(posedge i_clk) disable iff (!i_rstn)
        (!sync_mode && cont && spen) |=> o_rx_active;
    endproperty
    a_async_on: assert property (p_async_on)
        else $error("receiver off with continuous enable");

    property p_active_follow;
        @(posedge i_clk) disable iff (!i_rstn)
        rx_on |=> o_rx_active;
    endproperty
    a_active_follow: assert property (p_active_follow)
        else $error("active output lags receiver");

    property p_ctrl_write;
        @(posedge i_clk) disable iff (!i_rstn)
        wr_ctrl |=> (cont == $past(i_wdata[srcs_pkg::BIT_CONT]));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("continuous enable not written");

    property p_sync_nofilt;
        @(posedge i_clk) disable iff (!i_rstn)
        sync_mode |-> !filt;
    endproperty
    a_sync_nofilt: assert property (p_sync_nofilt)
        else $error("address filter active in sync mode");

    property p_nine_keep;
        @(posedge i_clk) disable iff (!i_rstn)
        (!filt && take) |-> (push || overrun_error_flag_r);
    endproperty
    a_nine_keep: assert property (p_nine_keep)
        else $error("unfiltered word not pushed");

    property p_head_framing_error_flag;
        @(posedge i_clk) disable iff (!i_rstn)
        (fifo_valid && !rd_data) |=>
            (ctrl_r[srcs_pkg::BIT_FRAMING_ERROR_FLAG] == fifo_out[9]);
    endproperty
    a_head_framing_error_flag: assert property (p_head_framing_error_flag)
        else $error("framing flag not from head word");

    property p_overrun_error_flag_clear;
        @(posedge i_clk) disable iff (!i_rstn)
        (!cont && !lost) |=> !overrun_error_flag_r;
    endproperty
    a_overrun_error_flag_clear: assert property (p_overrun_error_flag_clear)
        else $error("overrun kept without continuous");

    property p_overrun_error_flag_drop;
        @(posedge i_clk) disable iff (!i_rstn)
        overrun_error_flag_r |-> !push;
    endproperty
    a_overrun_error_flag_drop: assert property (p_overrun_error_flag_drop)
        else $error("word stored during overrun");

    property p_full_lost;
        @(posedge i_clk) disable iff (!i_rstn)
        (take && !fifo_ready) |-> !push_ok;
    endproperty
    a_full_lost: assert property (p_full_lost)
        else $error("word stored into full buffer");

    property p_head_rx9;
        @(posedge i_clk) disable iff (!i_rstn)
        (fifo_valid && !rd_data) |=>
            (ctrl_r[srcs_pkg::BIT_RX9] == fifo_out[8]);
    endproperty
    a_head_rx9: assert property (p_head_rx9)
        else $error("ninth bit not from head word");

    property p_store_rx9;
        @(posedge i_clk) disable iff (!i_rstn)
        push_ok |-> (word_in[8] == i_word_data[8]);
    endproperty
    a_store_rx9: assert property (p_store_rx9)
        else $error("ninth bit changed on store");

    c_single: cover property (@(posedge i_clk) single_done);
    c_overrun_error_flag_clear: cover property (@(posedge i_clk) overrun_error_flag_r && !cont);
    c_lost: cover property (@(posedge i_clk) lost);
    c_filtered: cover property (@(posedge i_clk) filt && take);
    c_full: cover property (@(posedge i_clk) !fifo_ready);
endmodule
